// ---- shared/pump_seq_params.svh ----
`ifndef PUMP_SEQ_PARAMS_SVH
`define PUMP_SEQ_PARAMS_SVH
// ==========================================================
// timebase
`define CLK_MHZ 250
`define TICK_MS 100
`define TICK_CYCLES (`TICK_MS * `CLK_MHZ * 1000)
`define TICKS_PER_HOUR (3600 * 1000 / `TICK_MS)
// ==========================================================
// pump mode codes
`define MODE_OFF 4'h0
`define MODE_FIXED_LIFO 4'h1
`define MODE_FIXED_MAX 4'h3
`define MODE_ALT_4 4'h4
`define MODE_ALT_5 4'h5
`define MODE_BOARD_6 4'h6
`define MODE_BOARD_7 4'h7
`define MODE_ALT_8 4'h8
`define MODE_BOARD_9 4'h9
`define MODE_FIXED_2 4'h2
// ==========================================================
// selectors
`define SRC_CARD 1'b0
`define SRC_BOARD 1'b1
`define SEL_FREQ 1'b0
// ==========================================================
// ranges, in 0.1 s ticks, 0.1 % and hours
`define DWELL_MIN 13'h000A
`define DWELL_MAX 13'h1770
`define SWITCH_MIN 13'h0001
`define SWITCH_MAX 13'h00C8
`define BIAS_MAX 8'hC8
`define BIAS_SCALE 24'h0003E8
`define ROT_MAX 8'hF0
`endif

// ---- shared/pump_seq_pkg.sv ----
package pump_seq_pkg;
  typedef enum {st_idle, st_run, st_break, st_make} seq_state_t;
  typedef enum {act_stage, act_destage} seq_action_t;
endpackage

// ---- logic/tick_divider.sv ----
module tick_divider #(
  parameter int CYCLES = 25000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // one-cycle enable
  output logic tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;

  always_comb
  begin
    next_tick = 1'b0;
    next_count = count + 32'h00000001;
    if (count >= 32'(CYCLES - 1))
    begin
      next_count = 32'h00000000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule

// ---- logic/dwell_timer.sv ----
module dwell_timer #(
  parameter int W = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // timebase and qualifier
  input wire logic tick,
  input wire logic hold,
  input wire logic [W-1:0] limit,
  // expiry level
  output logic done
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // any drop of the qualifier restarts the count
  always_comb
  begin
    next_count = count;
    if (!hold)
      next_count = '0;
    else if (tick && count < limit)
      next_count = count + W'(1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else
      count <= next_count;
  end

  assign done = hold && count >= limit;

  a_dwell_restart: assert property (@(posedge clk) disable iff (rst)
    !hold |=> count == '0) else $error("dwell count kept after qualifier drop");
endmodule

// ---- logic/pump_staging_relay_sequencer.sv ----
`include "pump_seq_params.svh"

// Operation
// - card alternation: relays 1/2 plus enabled pairs
// - drive output leaves pump before transfer
// - alternation de-stage removes earliest started pump
// - board mode refuses relay four to eight enables
// - stage after upper threshold dwell
// - de-stage after lower threshold dwell
// - contactor delay around every transfer
// - stage threshold is upper minus bias
// - de-stage threshold is lower plus bias
// - source selects card or board relays
// - pump capacity follows mode and source
// - board relays leave general output duty
// - modes 7/8 rotate start motor by timer
// - rotation timer clears on change or power-up
// - criterion 0 uses lower frequency dwell
// - criterion 1 uses feedback above setpoint
// - stop option opens all, restarts first relay
// - mode 0 disables every pump relay
// - stop option only in modes 6, 7, 9
module pump_staging_relay_sequencer #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int TICKS_PER_HOUR = `TICKS_PER_HOUR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic [3:0] pump_mode,
  input wire logic relay_source,
  input wire logic [3:0] relay_en_low,
  input wire logic [3:0] relay_en_high,
  input wire logic [12:0] stage_dwell,
  input wire logic [12:0] destage_dwell,
  input wire logic [12:0] switch_delay,
  input wire logic [7:0] bias,
  input wire logic [7:0] rotation_hours,
  input wire logic destage_select,
  input wire logic stop_mode_en,
  // drive state
  input wire logic run,
  input wire logic sleep,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] max_freq,
  input wire logic [15:0] upper_freq,
  input wire logic [15:0] lower_freq,
  input wire logic [15:0] feedback,
  input wire logic [15:0] setpoint,
  // relay outputs
  output logic [7:0] card_relays,
  output logic board_relay_one,
  output logic board_relay_two,
  output logic board_relay_three,
  output logic [2:0] board_relay_claimed,
  // status
  output logic drive_connect,
  output logic config_error,
  output logic [3:0] line_count
);
  // ==========================================================
  // configuration decode
  logic mode_on, fixed, card_alt, board_only, inv_stop_only, rot_mode, stop_opt;
  logic cfg_ok;
  logic [7:0] usable;
  logic [12:0] stage_lim, destage_lim, switch_lim;
  logic [7:0] bias_lim;

  always_comb
  begin
    mode_on = pump_mode != `MODE_OFF && pump_mode <= `MODE_BOARD_9;
    fixed = pump_mode >= `MODE_FIXED_LIFO && pump_mode <= `MODE_FIXED_MAX;
    card_alt = pump_mode == `MODE_ALT_4 || pump_mode == `MODE_ALT_5
      || pump_mode == `MODE_ALT_8;
    board_only = pump_mode == `MODE_BOARD_6 || pump_mode == `MODE_BOARD_7
      || pump_mode == `MODE_BOARD_9;
    inv_stop_only = pump_mode == `MODE_FIXED_2 || pump_mode == `MODE_ALT_5
      || pump_mode == `MODE_BOARD_9;
    rot_mode = pump_mode == `MODE_BOARD_7 || pump_mode == `MODE_ALT_8;
    stop_opt = stop_mode_en && board_only;
    if (relay_source == `SRC_BOARD)
      cfg_ok = (fixed || board_only) && !relay_en_low[3]
        && relay_en_high == 4'h0;
    else
      cfg_ok = !board_only;
    // capacity: 8 or 4 on the card, 3 on the board
    if (!mode_on || !cfg_ok)
      usable = 8'h00;
    else if (relay_source == `SRC_BOARD)
      usable = {5'h00, relay_en_low[2], relay_en_low[1], 1'b1};
    else if (card_alt)
      usable = {4'h0, relay_en_high[3] & relay_en_high[2],
        relay_en_high[1] & relay_en_high[0],
        relay_en_low[3] & relay_en_low[2], 1'b1};
    else
      usable = {relay_en_high, relay_en_low[3:1], 1'b1};
    // out-of-range dwell, delay and bias settings are held to the documented span
    stage_lim = stage_dwell < `DWELL_MIN ? `DWELL_MIN
      : (stage_dwell > `DWELL_MAX ? `DWELL_MAX : stage_dwell);
    destage_lim = destage_dwell < `DWELL_MIN ? `DWELL_MIN
      : (destage_dwell > `DWELL_MAX ? `DWELL_MAX : destage_dwell);
    switch_lim = switch_delay < `SWITCH_MIN ? `SWITCH_MIN
      : (switch_delay > `SWITCH_MAX ? `SWITCH_MAX : switch_delay);
    bias_lim = bias > `BIAS_MAX ? `BIAS_MAX : bias;
  end

  // ==========================================================
  // thresholds
  logic [23:0] bias_prod;
  logic [15:0] bias_amt, stage_thr;
  logic [16:0] destage_thr;

  always_comb
  begin
    bias_prod = max_freq * bias_lim;
    bias_amt = 16'(bias_prod / `BIAS_SCALE);
    stage_thr = upper_freq > bias_amt ? upper_freq - bias_amt : 16'h0000;
    destage_thr = {1'b0, lower_freq} + {1'b0, bias_amt};
  end

  // ==========================================================
  // timers
  logic tick;
  logic stage_done, destage_done, delay_done;
  logic stage_cond, destage_cond, switch_cond;
  pump_seq_pkg::seq_state_t state, next_state;
  pump_seq_pkg::seq_action_t action, next_action;
  logic [7:0] on_line, next_on_line;
  logic [2:0] inv_pump, next_inv_pump;
  logic conn, next_conn;
  logic make_entry, next_make_entry;
  logic free_found;
  logic [2:0] free_pump;

  tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  always_comb
  begin
    stage_cond = state == pump_seq_pkg::st_run && free_found
      && out_freq >= stage_thr;
    if (destage_select == `SEL_FREQ)
      destage_cond = {1'b0, out_freq} < destage_thr;
    else
      destage_cond = feedback > setpoint;
    destage_cond = destage_cond && state == pump_seq_pkg::st_run
      && on_line != 8'h00;
    // the delay restarts for the second half of a transfer; a registered
    // entry flag drops the qualifier, since feeding back done would loop
    switch_cond = (state == pump_seq_pkg::st_break
      || state == pump_seq_pkg::st_make) && !make_entry;
  end

  dwell_timer #(.W(13)) u_stage (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .hold(stage_cond),
    .limit(stage_lim),
    .done(stage_done)
  );

  dwell_timer #(.W(13)) u_destage (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .hold(destage_cond),
    .limit(destage_select == `SEL_FREQ ? destage_lim : `SWITCH_MIN),
    .done(destage_done)
  );

  dwell_timer #(.W(13)) u_switch (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .hold(switch_cond),
    .limit(switch_lim),
    .done(delay_done)
  );

  // ==========================================================
  // rotation timer
  logic [31:0] rot_ticks, next_rot_ticks;
  logic [7:0] rot_count, next_rot_count, rot_prev;
  logic rot_expired, rot_take;

  always_comb
  begin
    rot_expired = rot_mode && rotation_hours != 8'h00
      && rot_count >= rotation_hours;
    rot_take = state == pump_seq_pkg::st_idle && run && !sleep && rot_expired
      && usable[1] && !stop_opt;
    next_rot_ticks = rot_ticks;
    next_rot_count = rot_count;
    if ((mode_on && rotation_hours != rot_prev) || rot_take)
    begin
      next_rot_ticks = 32'h00000000;
      next_rot_count = 8'h00;
    end
    else if (rot_mode && tick && rot_count < `ROT_MAX)
    begin
      next_rot_ticks = rot_ticks + 32'h00000001;
      if (rot_ticks >= 32'(TICKS_PER_HOUR - 1))
      begin
        next_rot_ticks = 32'h00000000;
        next_rot_count = rot_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rot_ticks <= 32'h00000000;
      rot_count <= 8'h00;
      rot_prev <= 8'h00;
    end
    else
    begin
      rot_ticks <= next_rot_ticks;
      rot_count <= next_rot_count;
      rot_prev <= rotation_hours;
    end
  end

  // ==========================================================
  // start order memory
  logic [2:0] order [0:7];
  logic [2:0] head, next_head, tail, next_tail;
  logic push, pop_old, pop_new;
  logic [2:0] victim;

  always_comb
  begin
    free_found = 1'b0;
    free_pump = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (usable[i] && !on_line[i] && inv_pump != 3'(i))
      begin
        free_found = 1'b1;
        free_pump = 3'(i);
      end
    end
    // first on, last off only in mode 1
    if (pump_mode == `MODE_FIXED_LIFO)
      victim = order[tail - 3'h1];
    else
      victim = order[head];
  end

  // ==========================================================
  // sequencer
  always_comb
  begin
    next_state = state;
    next_action = action;
    next_on_line = on_line & usable;
    next_inv_pump = inv_pump;
    next_conn = conn;
    next_make_entry = 1'b0;
    push = 1'b0;
    pop_old = 1'b0;
    pop_new = 1'b0;
    unique case (state)
      pump_seq_pkg::st_idle:
      begin
        next_conn = 1'b0;
        if (!inv_stop_only || stop_opt)
          next_on_line = 8'h00;
        if (run && !sleep && usable[0])
        begin
          next_inv_pump = rot_take ? 3'h1 : 3'h0;
          next_conn = 1'b1;
          next_state = pump_seq_pkg::st_run;
        end
      end
      pump_seq_pkg::st_run:
      begin
        if (!run || sleep || !usable[0])
        begin
          next_conn = 1'b0;
          next_state = pump_seq_pkg::st_idle;
        end
        else if (stage_done)
        begin
          next_conn = 1'b0;
          next_action = pump_seq_pkg::act_stage;
          next_state = pump_seq_pkg::st_break;
        end
        else if (destage_done)
        begin
          next_conn = 1'b0;
          next_action = pump_seq_pkg::act_destage;
          next_state = pump_seq_pkg::st_break;
        end
      end
      pump_seq_pkg::st_break:
      begin
        if (delay_done)
        begin
          next_state = pump_seq_pkg::st_make;
          next_make_entry = 1'b1;
          if (action == pump_seq_pkg::act_stage)
          begin
            push = 1'b1;
            if (fixed)
              next_on_line[free_pump] = 1'b1;
            else
            begin
              next_on_line[inv_pump] = 1'b1;
              next_inv_pump = free_pump;
            end
          end
          else
          begin
            pop_new = pump_mode == `MODE_FIXED_LIFO;
            pop_old = !pop_new;
            next_on_line[victim] = 1'b0;
          end
        end
      end
      pump_seq_pkg::st_make:
      begin
        if (delay_done)
        begin
          next_conn = 1'b1;
          next_state = pump_seq_pkg::st_run;
        end
      end
    endcase
    next_head = pop_old ? head + 3'h1 : head;
    next_tail = push ? tail + 3'h1 : (pop_new ? tail - 3'h1 : tail);
    if (next_on_line == 8'h00)
    begin
      next_head = 3'h0;
      next_tail = 3'h0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= pump_seq_pkg::st_idle;
      action <= pump_seq_pkg::act_stage;
      on_line <= 8'h00;
      inv_pump <= 3'h0;
      conn <= 1'b0;
      make_entry <= 1'b0;
      head <= 3'h0;
      tail <= 3'h0;
    end
    else
    begin
      state <= next_state;
      action <= next_action;
      on_line <= next_on_line;
      inv_pump <= next_inv_pump;
      conn <= next_conn;
      make_entry <= next_make_entry;
      head <= next_head;
      tail <= next_tail;
    end
  end

  // stored order needs no reset: entries are read only once pushed
  always_ff @(posedge clk)
  begin
    if (push)
      order[tail] <= fixed ? free_pump : inv_pump;
  end

  // ==========================================================
  // relay mapping
  logic [7:0] relays, next_card;
  logic [2:0] next_board, next_claimed;
  logic [3:0] next_count;

  always_comb
  begin
    relays = 8'h00;
    next_count = 4'h0;
    for (int p = 0; p < 8; p++)
    begin
      next_count = next_count + {3'h0, on_line[p]};
      if (card_alt && relay_source == `SRC_CARD)
      begin
        if (p < 4)
        begin
          relays[2 * p] = usable[p] && conn && inv_pump == 3'(p);
          relays[2 * p + 1] = usable[p] && on_line[p];
        end
      end
      else
        relays[p] = usable[p] && (on_line[p] || (conn && inv_pump == 3'(p)));
    end
    next_card = relay_source == `SRC_CARD ? relays : 8'h00;
    next_board = relay_source == `SRC_BOARD ? relays[2:0] : 3'h0;
    next_claimed = relay_source == `SRC_BOARD && mode_on
      ? {relay_en_low[2], relay_en_low[1], 1'b1} : 3'h0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      card_relays <= 8'h00;
      board_relay_one <= 1'b0;
      board_relay_two <= 1'b0;
      board_relay_three <= 1'b0;
      board_relay_claimed <= 3'h0;
      drive_connect <= 1'b0;
      config_error <= 1'b0;
      line_count <= 4'h0;
    end
    else
    begin
      card_relays <= next_card;
      board_relay_one <= next_board[0];
      board_relay_two <= next_board[1];
      board_relay_three <= next_board[2];
      board_relay_claimed <= next_claimed;
      drive_connect <= conn;
      config_error <= mode_on && !cfg_ok;
      line_count <= next_count;
    end
  end

  // ==========================================================
  // checks
  a_break_drive_off: assert property (@(posedge clk) disable iff (rst)
    state == pump_seq_pkg::st_break |=> !drive_connect)
    else $error("drive still connected during transfer");
  a_switch_wait: assert property (@(posedge clk) disable iff (rst)
    state == pump_seq_pkg::st_break && next_state == pump_seq_pkg::st_make
    |-> delay_done) else $error("transfer without contactor delay");
  a_stage_dwell: assert property (@(posedge clk) disable iff (rst)
    state == pump_seq_pkg::st_run && next_state == pump_seq_pkg::st_break
    && next_action == pump_seq_pkg::act_stage |-> stage_done && stage_cond)
    else $error("stage before dwell");
  a_destage_dwell: assert property (@(posedge clk) disable iff (rst)
    state == pump_seq_pkg::st_run && next_state == pump_seq_pkg::st_break
    && next_action == pump_seq_pkg::act_destage |-> destage_done)
    else $error("de-stage before dwell");
  a_board_no_card: assert property (@(posedge clk) disable iff (rst)
    relay_source == `SRC_BOARD ##1 relay_source == `SRC_BOARD
    |=> card_relays == 8'h00) else $error("card relay used on board source");
  a_mode_off_quiet: assert property (@(posedge clk) disable iff (rst)
    pump_mode == `MODE_OFF [*2] |=> card_relays == 8'h00
    && !board_relay_one && board_relay_claimed == 3'h0)
    else $error("relay active with pump control off");
  a_pair_disabled: assert property (@(posedge clk) disable iff (rst)
    card_alt && relay_source == `SRC_CARD && !(relay_en_high[1] & relay_en_high[0])
    |=> card_relays[5:4] == 2'h0) else $error("half-enabled pair used");
  a_board_cfg_err: assert property (@(posedge clk) disable iff (rst)
    mode_on && relay_source == `SRC_BOARD && relay_en_high != 4'h0
    |=> config_error) else $error("bad board enables accepted");
  a_rot_clear: assert property (@(posedge clk) disable iff (rst)
    mode_on && rotation_hours != rot_prev |=> rot_count == 8'h00)
    else $error("rotation timer not cleared");
endmodule

// ---- testbench/contactor_bank.sv ----
// ==========================================================
// contactor bank on the card relays
module contactor_bank #(
  parameter int PULL_IN = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // relay coils
  input wire logic [7:0] coil,
  // drive and line contacts of one pump closed together
  output logic short_seen
);
  logic [7:0] closed;
  int age [8];
  // contacts follow a coil only after PULL_IN cycles, kept below the drive delay
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      closed <= 8'h00;
      short_seen <= 1'b0;
      for (int i = 0; i < 8; i++) age[i] = 0;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        age[i] = (coil[i] == closed[i]) ? 0 : age[i] + 1;
        if (age[i] >= PULL_IN) closed[i] <= coil[i];
      end
      for (int p = 0; p < 4; p++)
        if (closed[2*p] && closed[2*p+1]) short_seen <= 1'b1;
    end
  end
endmodule

// ---- testbench/pump_staging_relay_sequencer_bench.sv ----
// ==========================================================
// pump sequencer bench
module pump_staging_relay_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] pump_mode = 4'h0;
  logic relay_source = 1'b0;
  logic [3:0] relay_en_low = 4'h0;
  logic [3:0] relay_en_high = 4'h0;
  logic [12:0] stage_dwell = 13'h000A;
  logic [12:0] destage_dwell = 13'h000A;
  logic [12:0] switch_delay = 13'h0002;
  logic [7:0] bias = 8'h32;
  logic [7:0] rotation_hours = 8'h00;
  logic destage_select = 1'b0;
  logic stop_mode_en = 1'b0;
  logic run = 1'b0;
  logic sleep = 1'b0;
  logic [15:0] out_freq = 16'h01F4;
  logic [15:0] feedback = 16'h0190;
  logic [15:0] setpoint = 16'h01F4;
  logic [7:0] card_relays;
  logic board_relay_one;
  logic board_relay_two;
  logic board_relay_three;
  logic [2:0] board_relay_claimed;
  logic drive_connect;
  logic config_error;
  logic [3:0] line_count;
  logic short_seen;
  wire logic [11:0] obs = {board_relay_three, board_relay_two, board_relay_one,
    drive_connect, card_relays};
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  // mode, source, enables low/high, expected error
  logic [13:0] cfg [5] = '{{4'h4, 1'b1, 4'h0, 4'h0, 1'b1}, {4'h6, 1'b0, 4'h0, 4'h0, 1'b1},
    {4'h1, 1'b1, 4'h8, 4'h0, 1'b1}, {4'h1, 1'b1, 4'h0, 4'h1, 1'b1},
    {4'h0, 1'b1, 4'h8, 4'hF, 1'b0}};

  always #2 clk = ~clk;

  // short tick and hour keep the run small
  pump_staging_relay_sequencer #(
    .TICK_CYCLES(10),
    .TICKS_PER_HOUR(5)
  ) dut (
    .clk(clk), .rst(rst), .pump_mode(pump_mode), .relay_source(relay_source),
    .relay_en_low(relay_en_low), .relay_en_high(relay_en_high),
    .stage_dwell(stage_dwell), .destage_dwell(destage_dwell),
    .switch_delay(switch_delay), .bias(bias), .rotation_hours(rotation_hours),
    .destage_select(destage_select), .stop_mode_en(stop_mode_en), .run(run),
    .sleep(sleep), .out_freq(out_freq), .max_freq(16'h03E8), .upper_freq(16'h0320),
    .lower_freq(16'h00C8), .feedback(feedback), .setpoint(setpoint),
    .card_relays(card_relays), .board_relay_one(board_relay_one),
    .board_relay_two(board_relay_two), .board_relay_three(board_relay_three),
    .board_relay_claimed(board_relay_claimed), .drive_connect(drive_connect),
    .config_error(config_error), .line_count(line_count)
  );

  contactor_bank partner (.clk(clk), .rst(rst), .coil(card_relays),
    .short_seen(short_seen));

  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // bounded wait on masked relay/drive outputs, then compare
  task automatic wait_on(input string what, input logic [11:0] mask, input logic [11:0] val);
    n = 0;
    while ((obs & mask) !== val && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check(what, {4'h0, val}, {4'h0, obs & mask});
  endtask

  task automatic setup(input logic [3:0] m, input logic s, input logic [3:0] lo);
    run = 1'b0;
    cyc(5);
    pump_mode = m;
    relay_source = s;
    relay_en_low = lo;
    relay_en_high = 4'h0;
    cyc(3);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // scenarios
  initial
  begin
    cyc(3);
    rst = 1'b0;
    check("reset outputs", 16'h0000, {config_error, board_relay_claimed, obs});
    for (int i = 0; i < 5; i++)
    begin
      {pump_mode, relay_source, relay_en_low, relay_en_high} = cfg[i][13:1];
      run = 1'b1;
      cyc(5);
      check("config_error", {15'h0000, cfg[i][0]}, {15'h0000, config_error});
      check("refused relays", 16'h0000, {4'h0, obs});
      run = 1'b0;
      cyc(3);
    end
    // card alternation, pair 3/4 usable
    setup(4'h4, 1'b0, 4'hC);
    run = 1'b1;
    wait_on("alt start", 12'h1FF, 12'h101);
    out_freq = 16'h02F8;
    wait_on("alt break", 12'h100, 12'h000);
    out_freq = 16'h01F4;
    wait_on("alt stage", 12'h1FF, 12'h002);
    check("drive off at transfer", 16'h0000, {15'h0000, drive_connect});
    check("delay length", 16'h0001, {15'h0000, n >= 10});
    wait_on("alt reconnect", 12'h1FF, 12'h106);
    check("line_count", 16'h0001, {12'h000, line_count});
    destage_select = 1'b1;
    feedback = 16'h0258;
    wait_on("alt destage", 12'h0FF, 12'h004);
    feedback = 16'h0190;
    destage_select = 1'b0;
    wait_on("alt settle", 12'h100, 12'h100);
    check("no short", 16'h0000, {15'h0000, short_seen});
    // fixed mode, card relay 2
    setup(4'h1, 1'b0, 4'h2);
    run = 1'b1;
    wait_on("fixed start", 12'h103, 12'h101);
    for (int i = 0; i < 2; i++)
    begin
      out_freq = 16'h02F8;
      cyc(70);
      out_freq = 16'h01F4;
      cyc(2);
    end
    out_freq = 16'h02E4;
    cyc(300);
    check("no stage below band", 16'h0101, {4'h0, obs & 12'h103});
    out_freq = 16'h02F8;
    wait_on("fixed stage", 12'h002, 12'h002);
    out_freq = 16'h01F4;
    check("fixed drive off", 16'h0000, {15'h0000, drive_connect});
    wait_on("fixed reconnect", 12'h100, 12'h100);
    out_freq = 16'h0104;
    cyc(300);
    check("no destage above band", 16'h0002, {4'h0, obs & 12'h002});
    out_freq = 16'h00F0;
    wait_on("fixed destage", 12'h002, 12'h000);
    out_freq = 16'h01F4;
    // board alternation with stop option
    setup(4'h6, 1'b1, 4'h6);
    stop_mode_en = 1'b1;
    cyc(3);
    check("claimed", 16'h0007, {13'h0000, board_relay_claimed});
    run = 1'b1;
    wait_on("board start", 12'hF00, 12'h300);
    out_freq = 16'h02F8;
    wait_on("board stage", 12'h400, 12'h400);
    out_freq = 16'h01F4;
    wait_on("board reconnect", 12'h100, 12'h100);
    run = 1'b0;
    wait_on("board stop", 12'hF00, 12'h000);
    run = 1'b1;
    wait_on("board restart", 12'hF00, 12'h300);
    // rotation timer expires while asleep
    stop_mode_en = 1'b0;
    setup(4'h8, 1'b0, 4'hC);
    sleep = 1'b1;
    run = 1'b1;
    rotation_hours = 8'h01;
    cyc(150);
    sleep = 1'b0;
    wait_on("rotated start", 12'h1FF, 12'h104);
    print_verdict();
  end
endmodule
